/* File: rtl/wdu_pkg.sv */
// Shared constants and carrier types of the watchdog timer unit
`default_nettype none

package wdu_pkg;

    // Register byte offsets on the Wishbone slave
    localparam int              ADDR_W        = 5;
    localparam logic [4:0]      OFF_CTRL      = 5'h00;
    localparam logic [4:0]      OFF_IRQ_STAT  = 5'h04;
    localparam logic [4:0]      OFF_IRQ_CLR   = 5'h08;
    localparam logic [4:0]      OFF_IRQ_EN    = 5'h0c;
    localparam logic [4:0]      OFF_STATE     = 5'h10;

    // Control register layout
    localparam int              SWEN_BIT      = 0;
    localparam int              PS_LSB        = 1;
    localparam int              PS_W          = 5;
    localparam logic [4:0]      PS_RESET      = 5'h0b;
    localparam logic [4:0]      PS_MAX_CODE   = 5'h12;
    localparam logic [4:0]      PS_MIN_CODE   = 5'h00;
    localparam logic [4:0]      RATIO_OFFSET  = 5'h05;
    localparam logic            SWEN_RESET    = 1'h0;

    // Counter of slow oscillator ticks, wide enough for 1:2^23
    localparam int              CNT_W         = 23;

    // Slow oscillator and nominal base tick
    localparam int              OSC_FREQ_HZ   = 31000;
    localparam int              BASE_TICK_US  = 1000;

    // Mode configuration codes
    localparam logic [1:0]      MODE_ALWAYS_ON    = 2'h3;
    localparam logic [1:0]      MODE_OFF_IN_SLEEP = 2'h2;
    localparam logic [1:0]      MODE_SOFTWARE     = 2'h1;
    localparam logic [1:0]      MODE_ALWAYS_OFF   = 2'h0;

    // Interrupt status bits
    localparam int              IRQ_W         = 2;
    localparam int              IRQ_TIMEOUT   = 0;
    localparam int              IRQ_WAKE      = 1;

    // State register bits
    localparam int              ST_ACTIVE     = 0;
    localparam int              ST_TO         = 1;
    localparam int              ST_PD         = 2;
    localparam int              ST_SLEEP      = 3;

    typedef struct packed {
        logic [PS_W-1:0] periodSelect;
        logic            softEnable;
    } wdu_ctrl_t;

    typedef struct packed {
        logic clearDog;
        logic sleepEnter;
        logic wakeIrq;
    } wdu_cpu_evt_t;

    typedef struct packed {
        logic tick;
        logic fail;
        logic startupRunning;
    } wdu_osc_t;

endpackage

`default_nettype wire

/* File: rtl/wdu_counter.sv */
// Watchdog tick counter with terminal compare
`default_nettype none

module wdu_counter #(
    parameter int W = 23
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Control
    input  wire logic         clear,
    input  wire logic         tick,
    input  wire logic [W-1:0] limit,
    // Result
    output var  logic [W-1:0] count,
    output var  logic         hit
);

    logic [W-1:0] count_q;

    assign count = count_q;
    assign hit   = tick && !clear && (count_q == limit);

    // Restart from zero after a hit
    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            count_q <= '0;
        end else if (hit) begin
            count_q <= '0;
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/wdu_irq_bank.sv */
// Sticky event status, enable mask and level interrupt
`default_nettype none

module wdu_irq_bank #(
    parameter int N = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Events
    input  wire logic [N-1:0] events,
    // Software access
    input  wire logic         clrWe,
    input  wire logic         enWe,
    input  wire logic [N-1:0] wrData,
    // State
    output var  logic [N-1:0] status,
    output var  logic [N-1:0] enable,
    output var  logic         irq
);

    logic [N-1:0] status_q;
    logic [N-1:0] status_d;
    logic [N-1:0] enable_q;
    logic         irq_q;

    // Set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (clrWe) begin
            status_d = status_d & ~wrData;
        end
        status_d = status_d | events;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_q <= '0;
        end else if (enWe) begin
            enable_q <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_d & enable_q);
        end
    end

    assign status = status_q;
    assign enable = enable_q;
    assign irq    = irq_q;

endmodule

`default_nettype wire

/* File: rtl/wdu_top.sv */
// Watchdog timer unit: modes, clearing, time-out and Wishbone registers
`default_nettype none

// Contract
// - Counter advances on ticks of the slow internal oscillator, 1 ms base.
// - Active watchdog not cleared before time-out resets the device.
// - Mode 11 keeps the watchdog active always, Sleep included.
// - Mode 10 is active when awake, disabled in Sleep.
// - Mode 01 follows the soft enable bit; Sleep does not change it.
// - Mode 00 disables the watchdog and ignores the soft enable bit.
// - Five-bit period select sets 32 ms to about 8389 s (2^5 to 2^23 ticks); resets to code 11, about 65.5 s.
// - Counter clears on reset, clear instruction, Sleep, wake, failures, disable.
// - Sleep entry clears the counter; enabled counting resumes from zero.
// - Sleep exit clears the counter and holds it during start-up timer.
// - Time-out in Sleep wakes device and updates timeout and powerdown flags.
// - Mode 01 with soft enable 0 clears and disables the counter.
// - Clock switches and divider changes leave the counter untouched.
// - Period code n up to 18 selects prescale ratio 1:2^(n+5); codes above 18 select 1:32.
module wdu_top (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    // Wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [wdu_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [31:0]                 wb_dat_i,
    input  wire logic [3:0]                  wb_sel_i,
    output var  logic [31:0]                 wb_dat_o,
    output var  logic                        wb_ack_o,
    // Configuration word and device state
    input  wire logic [1:0]                  wdogModeConfig,
    input  wire logic                        sleepActive,
    // CPU events, one-cycle pulses
    input  wire wdu_pkg::wdu_cpu_evt_t       cpuEvt,
    // Slow oscillator status
    input  wire wdu_pkg::wdu_osc_t           oscStat,
    // Results
    output var  logic                        deviceReset,
    output var  logic                        wakeRequest,
    output var  logic                        timeoutFlag,
    output var  logic                        powerdownFlag,
    output var  logic                        irq
);

    // Control register and bus state
    wdu_pkg::wdu_ctrl_t            ctrl_q;
    logic                          ack_q;
    logic [31:0]                   rdData_q;
    logic [31:0]                   rdData_d;

    // Watchdog state
    logic                          sleep_q;
    logic                          active;
    logic                          sleepExit;
    logic                          cntClear;
    logic [wdu_pkg::PS_W-1:0]      effPs;
    logic [wdu_pkg::PS_W-1:0]      shamt;
    logic [wdu_pkg::CNT_W:0]       ratioWide;
    logic [wdu_pkg::CNT_W-1:0]     limit;
    logic                          hit;

    // Outputs and flags
    logic                          deviceReset_q;
    logic                          wakeRequest_q;
    logic                          timeoutFlag_q;
    logic                          powerdownFlag_q;

    // Bus decode
    logic                          busReq;
    logic                          wrLow;
    logic                          wrCtrl;
    logic                          wrIrqClr;
    logic                          wrIrqEn;
    logic                          addrHit;

    // Interrupt bank
    logic [wdu_pkg::IRQ_W-1:0]     irqEvents;
    logic [wdu_pkg::IRQ_W-1:0]     irqStatus;
    logic [wdu_pkg::IRQ_W-1:0]     irqEnable;
    logic                          irqLine;

    localparam logic [wdu_pkg::CNT_W:0] ONE_WIDE = {{wdu_pkg::CNT_W{1'b0}}, 1'b1};

    // ---------------------------------------------------------------
    // Wishbone slave: one wait state, ack for one cycle per request
    // ---------------------------------------------------------------
    assign busReq   = wb_cyc_i && wb_stb_i && !ack_q;
    assign wrLow    = busReq && wb_we_i && wb_sel_i[0];
    assign wrCtrl   = wrLow && (wb_adr_i == wdu_pkg::OFF_CTRL);
    assign wrIrqClr = wrLow && (wb_adr_i == wdu_pkg::OFF_IRQ_CLR);
    assign wrIrqEn  = wrLow && (wb_adr_i == wdu_pkg::OFF_IRQ_EN);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq;
        end
    end

    // Read mux; unmapped and write-only locations read as zero
    always_comb begin
        rdData_d = '0;
        addrHit  = 1'b1;
        case (wb_adr_i)
            wdu_pkg::OFF_CTRL: begin
                rdData_d[wdu_pkg::SWEN_BIT] = ctrl_q.softEnable;
                rdData_d[wdu_pkg::PS_LSB +: wdu_pkg::PS_W] = ctrl_q.periodSelect;
            end
            wdu_pkg::OFF_IRQ_STAT: begin
                rdData_d[wdu_pkg::IRQ_W-1:0] = irqStatus;
            end
            wdu_pkg::OFF_IRQ_EN: begin
                rdData_d[wdu_pkg::IRQ_W-1:0] = irqEnable;
            end
            wdu_pkg::OFF_IRQ_CLR: begin
                rdData_d = '0;
            end
            wdu_pkg::OFF_STATE: begin
                rdData_d[wdu_pkg::ST_ACTIVE] = active;
                rdData_d[wdu_pkg::ST_TO]     = timeoutFlag_q;
                rdData_d[wdu_pkg::ST_PD]     = powerdownFlag_q;
                rdData_d[wdu_pkg::ST_SLEEP]  = sleep_q;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
        if (!addrHit || wb_we_i) begin
            rdData_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_q <= '0;
        end else if (busReq) begin
            rdData_q <= rdData_d;
        end else begin
            rdData_q <= '0;
        end
    end

    // ---------------------------------------------------------------
    // Control register: period select and soft enable
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q.periodSelect <= wdu_pkg::PS_RESET;
            ctrl_q.softEnable   <= wdu_pkg::SWEN_RESET;
        end else if (wrCtrl) begin
            ctrl_q.periodSelect <= wb_dat_i[wdu_pkg::PS_LSB +: wdu_pkg::PS_W];
            ctrl_q.softEnable   <= wb_dat_i[wdu_pkg::SWEN_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Operating mode
    // ---------------------------------------------------------------
    always_comb begin
        case (wdogModeConfig)
            wdu_pkg::MODE_ALWAYS_ON: begin
                active = 1'b1;
            end
            wdu_pkg::MODE_OFF_IN_SLEEP: begin
                active = !sleepActive;
            end
            wdu_pkg::MODE_SOFTWARE: begin
                active = ctrl_q.softEnable;
            end
            wdu_pkg::MODE_ALWAYS_OFF: begin
                active = 1'b0;
            end
            default: begin
                active = 1'b0;
            end
        endcase
    end

    // Sleep level tracked to find the exit edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleepActive;
        end
    end

    assign sleepExit = sleep_q && !sleepActive;

    // ---------------------------------------------------------------
    // Clearing; no clock-switch input exists so those leave it alone
    // ---------------------------------------------------------------
    assign cntClear = cpuEvt.clearDog
                   || cpuEvt.sleepEnter
                   || cpuEvt.wakeIrq
                   || sleepExit
                   || oscStat.startupRunning
                   || oscStat.fail
                   || !active;

    // ---------------------------------------------------------------
    // Prescale ratio from period select
    // ---------------------------------------------------------------
    always_comb begin
        if (ctrl_q.periodSelect > wdu_pkg::PS_MAX_CODE) begin
            effPs = wdu_pkg::PS_MIN_CODE;
        end else begin
            effPs = ctrl_q.periodSelect;
        end
        shamt     = effPs + wdu_pkg::RATIO_OFFSET;
        ratioWide = (ONE_WIDE << shamt) - ONE_WIDE;
        limit     = ratioWide[wdu_pkg::CNT_W-1:0];
    end

    wdu_counter #(
        .W      (wdu_pkg::CNT_W)
    ) u_counter (
        .clk    (clk),
        .sys_rst(sys_rst),
        .clear  (cntClear),
        .tick   (oscStat.tick),
        .limit  (limit),
        .count  (),
        .hit    (hit)
    );

    // ---------------------------------------------------------------
    // Time-out: reset when awake, wake when asleep
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            deviceReset_q <= 1'b0;
        end else begin
            deviceReset_q <= hit && !sleepActive;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wakeRequest_q <= 1'b0;
        end else begin
            wakeRequest_q <= hit && sleepActive;
        end
    end

    // Status flags are high-true "not timed out" and "not powered down"
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timeoutFlag_q <= 1'b1;
        end else if (hit) begin
            timeoutFlag_q <= 1'b0;
        end else if (cpuEvt.clearDog || cpuEvt.sleepEnter) begin
            timeoutFlag_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powerdownFlag_q <= 1'b1;
        end else if (cpuEvt.sleepEnter || (hit && sleepActive)) begin
            powerdownFlag_q <= 1'b0;
        end else if (cpuEvt.clearDog) begin
            powerdownFlag_q <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Interrupts
    // ---------------------------------------------------------------
    always_comb begin
        irqEvents = '0;
        irqEvents[wdu_pkg::IRQ_TIMEOUT] = hit && !sleepActive;
        irqEvents[wdu_pkg::IRQ_WAKE]    = hit && sleepActive;
    end

    wdu_irq_bank #(
        .N      (wdu_pkg::IRQ_W)
    ) u_irq (
        .clk    (clk),
        .sys_rst(sys_rst),
        .events (irqEvents),
        .clrWe  (wrIrqClr),
        .enWe   (wrIrqEn),
        .wrData (wb_dat_i[wdu_pkg::IRQ_W-1:0]),
        .status (irqStatus),
        .enable (irqEnable),
        .irq    (irqLine)
    );

    // ---------------------------------------------------------------
    // Outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign wb_ack_o      = ack_q;
    assign wb_dat_o      = rdData_q;
    assign deviceReset   = deviceReset_q;
    assign wakeRequest   = wakeRequest_q;
    assign timeoutFlag   = timeoutFlag_q;
    assign powerdownFlag = powerdownFlag_q;
    assign irq           = irqLine;

endmodule

`default_nettype wire

/* File: test/wdu_top_props.sv */
// Concurrent checks on the watchdog timer unit ports
`default_nettype none

module wdu_top_props (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // Wishbone slave
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    // Configuration and events
    input wire logic [1:0]            wdogModeConfig,
    input wire logic                  sleepActive,
    input wire wdu_pkg::wdu_cpu_evt_t cpuEvt,
    input wire wdu_pkg::wdu_osc_t     oscStat,
    // Results
    input wire logic                  deviceReset,
    input wire logic                  wakeRequest,
    input wire logic                  timeoutFlag,
    input wire logic                  powerdownFlag,
    input wire logic                  irq
);
    logic [23:0] tickCnt_q;

    // Ticks since the last clearing event
    always_ff @(posedge clk) begin
        if (sys_rst || cpuEvt.clearDog || cpuEvt.sleepEnter || cpuEvt.wakeIrq
            || oscStat.fail || oscStat.startupRunning) begin
            tickCnt_q <= 24'h0;
        end else if (deviceReset || wakeRequest) begin
            tickCnt_q <= {23'h0, oscStat.tick};
        end else if (oscStat.tick) begin
            tickCnt_q <= tickCnt_q + 24'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_ack_once: assert property (s_req |=> s_ack_once)
        else $error("bus ack missing or too long");
    a_bus_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_state: assert property (disable iff (1'b0) sys_rst |=>
        timeoutFlag && powerdownFlag && !deviceReset && !wakeRequest && !irq)
        else $error("outputs wrong after reset");
    a_off_silent: assert property ((deviceReset || wakeRequest) |->
        $past(wdogModeConfig) != wdu_pkg::MODE_ALWAYS_OFF)
        else $error("time-out while disabled");
    a_reset_awake: assert property (deviceReset |->
        !$past(sleepActive) && !timeoutFlag)
        else $error("device reset not from awake time-out");
    a_wake_sleep: assert property (wakeRequest |->
        $past(sleepActive) && !timeoutFlag && !powerdownFlag)
        else $error("wake without sleep time-out flags");
    a_sleep_off: assert property (wakeRequest |->
        $past(wdogModeConfig) != wdu_pkg::MODE_OFF_IN_SLEEP)
        else $error("wake in mode off-in-sleep");
    a_ratio_min: assert property ((deviceReset || wakeRequest) |->
        $past(oscStat.tick) && $past(tickCnt_q) >= 24'h1f)
        else $error("time-out before the minimum tick count");
    a_clear_flags: assert property (cpuEvt.clearDog && !oscStat.tick |=>
        timeoutFlag && powerdownFlag)
        else $error("clear did not restore flags");
    a_sleep_flags: assert property (cpuEvt.sleepEnter && !oscStat.tick |=>
        timeoutFlag && !powerdownFlag)
        else $error("sleep entry flags wrong");
endmodule

bind wdu_top wdu_top_props i_wdu_top_props (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wdogModeConfig, .sleepActive, .cpuEvt, .oscStat,
    .deviceReset, .wakeRequest, .timeoutFlag, .powerdownFlag, .irq);

`default_nettype wire

/* File: test/wdu_cpu_model.sv */
// Behavioural CPU core issuing clear, Sleep and wake events
`default_nettype none

module wdu_cpu_model (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // Bench commands, one cycle each
    input  wire logic                  clearCmd,
    input  wire logic                  sleepCmd,
    input  wire logic                  wakeCmd,
    // Watchdog result
    input  wire logic                  wakeRequest,
    // Core events and state
    output var  wdu_pkg::wdu_cpu_evt_t cpuEvt,
    output var  logic                  sleepActive
);
    // A sleeping core executes nothing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cpuEvt <= '0;
        end else begin
            cpuEvt.clearDog   <= clearCmd && !sleepActive;
            cpuEvt.sleepEnter <= sleepCmd && !sleepActive;
            cpuEvt.wakeIrq    <= wakeCmd && sleepActive;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleepActive <= 1'b0;
        end else if (cpuEvt.sleepEnter) begin
            sleepActive <= 1'b1;
        end else if (cpuEvt.wakeIrq || wakeRequest) begin
            sleepActive <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* File: test/watchdog_timer_unit_bench.sv */
// Self-checking bench of the watchdog timer unit
`default_nettype none

module watchdog_timer_unit_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic                  wbCyc = 1'b0;
    logic                  wbStb = 1'b0;
    logic                  wbWe = 1'b0;
    logic [4:0]            wbAdr = 5'h00;
    logic [31:0]           wbDatW = 32'h0;
    logic [3:0]            wbSel = 4'h0;
    logic [31:0]           wbDatR;
    logic                  wbAck;
    logic [1:0]            mode = 2'h0;
    logic                  sleepActive;
    wdu_pkg::wdu_cpu_evt_t cpuEvt;
    wdu_pkg::wdu_osc_t     osc = '0;
    logic                  deviceReset, wakeRequest, timeoutFlag, powerdownFlag, irq;
    logic                  clrCmd = 1'b0, sleepCmd = 1'b0, wakeCmd = 1'b0;
    logic [31:0]           rd;
    logic [4:0]            psList [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1f};
    int                    error_cnt = 0, checks = 0, rstCnt = 0, wakeCnt = 0;
    int                    kinds [5] = '{0, 1, 3, 4, 2};

    wdu_top i_wdu_top (.clk, .sys_rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .wdogModeConfig(mode), .sleepActive, .cpuEvt, .oscStat(osc),
        .deviceReset, .wakeRequest, .timeoutFlag, .powerdownFlag, .irq);
    wdu_cpu_model i_wdu_cpu_model (.clk, .sys_rst, .clearCmd(clrCmd), .sleepCmd,
        .wakeCmd, .wakeRequest, .cpuEvt, .sleepActive);

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (deviceReset === 1'b1) rstCnt++;
        if (wakeRequest === 1'b1) wakeCnt++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wbXfer(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                          input logic [3:0] sel);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        wbSel <= sel;
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic rdChk(input logic [4:0] adr, input logic [31:0] exp);
        wbXfer(1'b0, adr, 32'h0, 4'hf);
        chk(rd, exp);
    endtask

    // Kinds: 0 clear, 1 sleep, 2 wake, 3 oscillator fail, 4 start-up timer
    task automatic cmd(input int k);
        @(posedge clk);
        case (k)
            0: clrCmd <= 1'b1;
            1: sleepCmd <= 1'b1;
            2: wakeCmd <= 1'b1;
            3: osc.fail <= 1'b1;
            default: osc.startupRunning <= 1'b1;
        endcase
        @(posedge clk);
        clrCmd <= 1'b0;
        sleepCmd <= 1'b0;
        wakeCmd <= 1'b0;
        osc.fail <= 1'b0;
        osc.startupRunning <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            osc.tick <= 1'b1;
            @(posedge clk);
            osc.tick <= 1'b0;
            repeat ($urandom_range(2, 0)) @(posedge clk);
        end
        repeat (3) @(posedge clk);
    endtask

    function automatic int ratio(input logic [4:0] ps);
        return (ps > wdu_pkg::PS_MAX_CODE) ? 32 : (1 << (int'(ps) + 5));
    endfunction

    function automatic logic expAct(input logic [1:0] m, input logic sw, input logic sl);
        case (m)
            2'h3: return 1'b1;
            2'h2: return !sl;
            2'h1: return sw;
            default: return 1'b0;
        endcase
    endfunction

    task automatic results;
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        results;
    end

    initial begin
        int c, w, r;
        logic [31:0] v;
        void'($urandom(32'h6425725d));
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk(wdu_pkg::OFF_CTRL, 32'h16);
        rdChk(wdu_pkg::OFF_STATE, 32'h6);
        repeat (4) begin
            v = $urandom;
            wbXfer(1'b1, wdu_pkg::OFF_CTRL, v, 4'hf);
            rdChk(wdu_pkg::OFF_CTRL, v & 32'h3f);
        end
        wbXfer(1'b1, wdu_pkg::OFF_CTRL, 32'h0, 4'he);
        rdChk(wdu_pkg::OFF_CTRL, v & 32'h3f);
        wbXfer(1'b1, 5'h14, 32'hff, 4'hf);
        rdChk(5'h14, 32'h0);
        wbXfer(1'b1, wdu_pkg::OFF_IRQ_EN, 32'h3, 4'hf);
        mode <= 2'h3;
        // Period codes, reserved ones among them
        foreach (psList[i]) begin
            r = ratio(psList[i]);
            wbXfer(1'b1, wdu_pkg::OFF_CTRL, {26'h0, psList[i], 1'b1}, 4'hf);
            cmd(0);
            c = rstCnt;
            ticks(r - 1);
            chk(rstCnt - c, 0);
            ticks(1);
            chk(rstCnt - c, 1);
            chk(timeoutFlag, 0);
            ticks(r);
            chk(rstCnt - c, 2);
        end
        // Interrupt raised, cleared, masked
        chk(irq, 1);
        rdChk(wdu_pkg::OFF_IRQ_STAT, 32'h1);
        wbXfer(1'b1, wdu_pkg::OFF_IRQ_CLR, 32'h1, 4'hf);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        wbXfer(1'b1, wdu_pkg::OFF_IRQ_EN, 32'h0, 4'hf);
        cmd(0);
        ticks(32);
        rdChk(wdu_pkg::OFF_IRQ_STAT, 32'h1);
        chk(irq, 0);
        wbXfer(1'b1, wdu_pkg::OFF_IRQ_CLR, 32'h3, 4'hf);
        // Clearing events in mid-count
        foreach (kinds[i]) begin
            cmd(0);
            c = rstCnt + wakeCnt;
            if (kinds[i] == 2) cmd(1);
            ticks(20);
            if (kinds[i] == 4) begin
                osc.startupRunning <= 1'b1;
                ticks(40);
            end
            cmd(kinds[i]);
            ticks(31);
            chk(rstCnt + wakeCnt - c, 0);
            ticks(1);
            chk(rstCnt + wakeCnt - c, 1);
        end
        // Mode table, awake and asleep
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                for (int sl = 0; sl < 2; sl++) begin
                    mode <= 2'(m);
                    wbXfer(1'b1, wdu_pkg::OFF_CTRL, 32'(s), 4'hf);
                    cmd(0);
                    if (sl == 1) cmd(1);
                    c = rstCnt;
                    w = wakeCnt;
                    ticks(32);
                    r = int'(expAct(2'(m), 1'(s), 1'(sl)));
                    chk(rstCnt - c, r * (1 - sl));
                    chk(wakeCnt - w, r * sl);
                    if (sleepActive === 1'b1) cmd(2);
                end
            end
        end
        results;
    end
endmodule

`default_nettype wire
